// ---- rtl/result_readback_defines.svh ----
// register offsets, field positions and reset values of the result read-back bank
`ifndef RESULT_READBACK_DEFINES_SVH
`define RESULT_READBACK_DEFINES_SVH

`define ADDR_LOOP_CONFIG 8'h2F
`define ADDR_STATUS 8'h30
`define ADDR_PACE1_HIGH 8'h31
`define ADDR_PACE1_LOW 8'h32
`define ADDR_PACE2_HIGH 8'h33
`define ADDR_PACE2_LOW 8'h34
`define ADDR_PACE3_HIGH 8'h35
`define ADDR_PACE3_LOW 8'h36
`define ADDR_ECG1_HIGH 8'h37
`define ADDR_ECG1_MID 8'h38
`define ADDR_ECG1_LOW 8'h39
`define ADDR_ECG2_HIGH 8'h3A
`define ADDR_ECG2_MID 8'h3B
`define ADDR_ECG2_LOW 8'h3C
`define ADDR_ECG3_HIGH 8'h3D
`define ADDR_ECG3_MID 8'h3E
`define ADDR_ECG3_LOW 8'h3F
`define ADDR_REVISION 8'h40
`define ADDR_LOOP_PORT 8'h50

// value is arbitrary
`define REVISION_VALUE 8'hA5
`define LOOP_CONFIG_RESET 7'h00
`define LOOP_CONFIG_MASK 8'h7F

// enable bit positions in the loop select config register
`define BIT_STATUS_EN 0
`define BIT_PACE1_EN 1
`define BIT_PACE2_EN 2
`define BIT_PACE3_EN 3
`define BIT_ECG1_EN 4
`define BIT_ECG2_EN 5
`define BIT_ECG3_EN 6

// status byte field positions
`define BIT_ALARM 1
`define BIT_PACE1_RDY 2
`define BIT_ECG1_RDY 5

`define LOOP_SLOTS 16
`endif

// ---- rtl/result_readback_pkg.sv ----
// types shared by the result read-back bank
package result_readback_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] slot_t;
  typedef logic [15:0] pace_t;
  typedef logic [23:0] ecg_t;
endpackage : result_readback_pkg

// ---- rtl/input_sync.sv ----
// three-stage synchroniser for the asynchronous alarm level
`timescale 1ns/1ps
module input_sync (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic asyncIn, // level from outside the domain
  output logic syncOut // filtered level
);
  logic meta_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      s2_q <= meta_q;
      s3_q <= s2_q;
      // a change counts only once stages two and three agree
      if (s2_q == s3_q) begin
        syncOut <= s3_q;
      end
    end
  end
endmodule : input_sync

// ---- rtl/loop_slot_picker.sv ----
// finds the next enabled slot of the loop read-back walk
`timescale 1ns/1ps
module loop_slot_picker (
  input wire logic [15:0] slotEnable, // one bit per address 0x30..0x3F
  input wire result_readback_pkg::slot_t cur, // slot just returned
  output result_readback_pkg::slot_t nextSlot, // next enabled slot after cur, wrapping
  output logic anyEnabled // at least one slot enabled
);
  import result_readback_pkg::*;
  slot_t idx;
  always_comb begin
    nextSlot = cur;
    idx = '0;
    // scan downward so the nearest enabled slot above cur wins
    for (int k = 15; k >= 1; k--) begin
      idx = cur + slot_t'(k);
      if (slotEnable[idx]) begin
        nextSlot = idx;
      end
    end
  end
  assign anyEnabled = |slotEnable;
endmodule : loop_slot_picker

// ---- rtl/result_readback.sv ----
// read-only result register bank with loop read-back port
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "result_readback_defines.svh"
module result_readback (
  input wire logic clock, // 200 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire result_readback_pkg::byte_t regAddr, // register address
  input wire result_readback_pkg::byte_t regWdata, // write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output result_readback_pkg::byte_t regRdata, // read data, valid the cycle after regRead
  input wire result_readback_pkg::pace_t pace1Result, // channel-one pace result
  input wire result_readback_pkg::pace_t pace2Result, // channel-two pace result
  input wire result_readback_pkg::pace_t pace3Result, // channel-three pace result
  input wire result_readback_pkg::ecg_t ecg1Result, // channel-one ECG result
  input wire result_readback_pkg::ecg_t ecg2Result, // channel-two ECG result
  input wire result_readback_pkg::ecg_t ecg3Result, // channel-three ECG result
  input wire logic [2:0] paceReady, // pace ready flags, channels 3..1
  input wire logic [2:0] ecgReady, // ECG ready flags, channels 3..1
  input wire logic alarmActive, // alarm level, asynchronous
  output logic [6:0] loopSelectConfig // loop enables, for the block's other logic
);
  import result_readback_pkg::*;

  logic alarmSync;
  byte_t statusByte;
  byte_t slotData [16];
  logic [15:0] slotEnable;
  slot_t loopPtr_q;
  slot_t loopPtr_d;
  slot_t firstSlot;
  slot_t nextSlot;
  logic anyEnabled;
  logic loopRead;
  logic inRange;
  byte_t directData;
  byte_t readData;
  logic [6:0] loopSelectConfig_q;

  input_sync alarmSyncInst (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn(alarmActive),
    .syncOut(alarmSync)
  );

  // status byte: ready flags above the alarm flag, bit 0 reads zero
  assign statusByte = {ecgReady, paceReady, alarmSync, 1'b0};

  // byte slots 0x30..0x3F, most significant byte first
  assign slotData[0] = statusByte;
  assign slotData[1] = pace1Result[15:8];
  assign slotData[2] = pace1Result[7:0];
  assign slotData[3] = pace2Result[15:8];
  assign slotData[4] = pace2Result[7:0];
  assign slotData[5] = pace3Result[15:8];
  assign slotData[6] = pace3Result[7:0];
  assign slotData[7] = ecg1Result[23:16];
  assign slotData[8] = ecg1Result[15:8];
  assign slotData[9] = ecg1Result[7:0];
  assign slotData[10] = ecg2Result[23:16];
  assign slotData[11] = ecg2Result[15:8];
  assign slotData[12] = ecg2Result[7:0];
  assign slotData[13] = ecg3Result[23:16];
  assign slotData[14] = ecg3Result[15:8];
  assign slotData[15] = ecg3Result[7:0];

  // each enable bit opens the slots of its register
  assign slotEnable = {
    {3{loopSelectConfig_q[`BIT_ECG3_EN]}},
    {3{loopSelectConfig_q[`BIT_ECG2_EN]}},
    {3{loopSelectConfig_q[`BIT_ECG1_EN]}},
    {2{loopSelectConfig_q[`BIT_PACE3_EN]}},
    {2{loopSelectConfig_q[`BIT_PACE2_EN]}},
    {2{loopSelectConfig_q[`BIT_PACE1_EN]}},
    loopSelectConfig_q[`BIT_STATUS_EN]
  };

  // the walk restarts from slot 15 so the first pick is the lowest enabled slot
  assign firstSlot = 4'hF;

  loop_slot_picker pickerInst (
    .slotEnable(slotEnable),
    .cur(loopPtr_q),
    .nextSlot(nextSlot),
    .anyEnabled(anyEnabled)
  );

  assign loopRead = regRead && (regAddr == `ADDR_LOOP_PORT);
  assign inRange = (regAddr & 8'hF0) == `ADDR_STATUS;

  // slot 15 only opens together with slot 13, so a walk restarted at 15 always lands on the lowest open slot
  slot_t loopSel;
  assign loopSel = nextSlot;

  assign directData = (regAddr == `ADDR_LOOP_CONFIG) ? {1'b0, loopSelectConfig_q} :
                      (regAddr == `ADDR_REVISION) ? `REVISION_VALUE :
                      inRange ? slotData[regAddr[3:0]] : 8'h00;

  // a loop read with nothing enabled returns zero
  assign readData = loopRead ? (anyEnabled ? slotData[loopSel] : 8'h00) : directData;

  assign loopPtr_d = loopRead && anyEnabled ? loopSel : loopPtr_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      loopSelectConfig_q <= `LOOP_CONFIG_RESET;
    end else if (regWrite && regAddr == `ADDR_LOOP_CONFIG) begin
      // only the config register takes writes; result and revision writes fall away
      loopSelectConfig_q <= regWdata[6:0];
    end
  end

  // a config write restarts the walk at the lowest enabled slot
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      loopPtr_q <= 4'hF;
    end else if (regWrite && regAddr == `ADDR_LOOP_CONFIG) begin
      loopPtr_q <= firstSlot;
    end else if (loopRead && anyEnabled) begin
      loopPtr_q <= loopPtr_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      loopSelectConfig <= 7'h00;
    end else begin
      regRdata <= regRead ? readData : 8'h00;
      loopSelectConfig <= loopSelectConfig_q;
    end
  end

  a_revision_read: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_REVISION |=> regRdata == `REVISION_VALUE)
    else $error("revision read wrong");
  a_pace1_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE1_HIGH |=> regRdata == $past(pace1Result[15:8]))
    else $error("pace1 high byte wrong");
  a_pace2_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE2_LOW |=> regRdata == $past(pace2Result[7:0]))
    else $error("pace2 low byte wrong");
  a_pace3_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE3_HIGH |=> regRdata == $past(pace3Result[15:8]))
    else $error("pace3 high byte wrong");
  a_ecg1_mid: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG1_MID |=> regRdata == $past(ecg1Result[15:8]))
    else $error("ecg1 middle byte wrong");
  a_ecg2_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG2_HIGH |=> regRdata == $past(ecg2Result[23:16]))
    else $error("ecg2 high byte wrong");
  a_ecg3_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG3_LOW |=> regRdata == $past(ecg3Result[7:0]))
    else $error("ecg3 low byte wrong");
  a_loop_disabled: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_LOOP_PORT && !anyEnabled |=> regRdata == 8'h00)
    else $error("loop read with nothing enabled not zero");
  a_loop_enabled_only: assert property (@(posedge clock) disable iff (sys_rst)
    loopRead && anyEnabled |=> slotEnable[loopPtr_q])
    else $error("loop walk landed on a disabled slot");
  a_status_bit0: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_STATUS |=> regRdata[0] == 1'b0)
    else $error("status reserved bit set");
  a_readonly_hold: assert property (@(posedge clock) disable iff (sys_rst)
    regWrite && regAddr != `ADDR_LOOP_CONFIG |=> $stable(loopSelectConfig_q))
    else $error("write to read-only register changed state");

  // walk steps as seen on the register port
  sequence configWrite;
    regWrite && regAddr == `ADDR_LOOP_CONFIG;
  endsequence : configWrite
  sequence loopStep;
    loopRead && anyEnabled;
  endsequence : loopStep
  sequence loopIdleRead;
    loopRead && !anyEnabled;
  endsequence : loopIdleRead
  // a loop read that has just landed on slot s; its data stand at the same edge
  sequence loopLanded(slot_t s);
    loopStep ##1 loopPtr_q == s;
  endsequence : loopLanded

  // true when an open slot lies strictly between two walk positions, counting upward with wrap
  function automatic logic slotBetween(input logic [15:0] en, input slot_t from, input slot_t to);
    slot_t idx;
    logic scanning;
    logic hit;
    scanning = 1'b1;
    hit = 1'b0;
    for (int k = 1; k < 16; k++) begin
      idx = from + slot_t'(k);
      if (idx == to) begin
        scanning = 1'b0;
      end
      if (scanning && en[idx]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : slotBetween

  a_pace1_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE1_LOW |=> regRdata == $past(pace1Result[7:0]))
    else $error("pace1 low byte wrong");
  a_pace2_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE2_HIGH |=> regRdata == $past(pace2Result[15:8]))
    else $error("pace2 high byte wrong");
  a_pace3_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_PACE3_LOW |=> regRdata == $past(pace3Result[7:0]))
    else $error("pace3 low byte wrong");
  a_ecg1_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG1_HIGH |=> regRdata == $past(ecg1Result[23:16]))
    else $error("ecg1 high byte wrong");
  a_ecg1_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG1_LOW |=> regRdata == $past(ecg1Result[7:0]))
    else $error("ecg1 low byte wrong");
  a_ecg2_mid: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG2_MID |=> regRdata == $past(ecg2Result[15:8]))
    else $error("ecg2 middle byte wrong");
  a_ecg2_low: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG2_LOW |=> regRdata == $past(ecg2Result[7:0]))
    else $error("ecg2 low byte wrong");
  a_ecg3_high: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG3_HIGH |=> regRdata == $past(ecg3Result[23:16]))
    else $error("ecg3 high byte wrong");
  a_ecg3_mid: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_ECG3_MID |=> regRdata == $past(ecg3Result[15:8]))
    else $error("ecg3 middle byte wrong");
  a_status_read: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_STATUS |=> regRdata == {$past(ecgReady), $past(paceReady), $past(alarmSync), 1'b0})
    else $error("status byte wrong");
  a_config_read: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && regAddr == `ADDR_LOOP_CONFIG |=> regRdata == {1'b0, $past(loopSelectConfig_q)})
    else $error("config read wrong");
  a_config_write: assert property (@(posedge clock) disable iff (sys_rst)
    configWrite |=> loopSelectConfig_q == $past(regWdata[6:0]))
    else $error("config write not taken");
  a_config_mirror: assert property (@(posedge clock) disable iff (sys_rst)
    1'b1 |=> loopSelectConfig == $past(loopSelectConfig_q))
    else $error("config copy out of step");
  a_idle_zero: assert property (@(posedge clock) disable iff (sys_rst)
    !regRead |=> regRdata == 8'h00)
    else $error("read data not zero without a read");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst)
    regRead && !inRange && regAddr != `ADDR_LOOP_CONFIG && regAddr != `ADDR_REVISION &&
    regAddr != `ADDR_LOOP_PORT |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_state: assert property (@(posedge clock)
    sys_rst |=> loopSelectConfig_q == `LOOP_CONFIG_RESET && loopPtr_q == 4'hF && regRdata == 8'h00)
    else $error("state not cleared by reset");
  a_loop_restart: assert property (@(posedge clock) disable iff (sys_rst)
    configWrite |=> loopPtr_q == 4'hF)
    else $error("config write did not restart the walk");
  a_loop_hold: assert property (@(posedge clock) disable iff (sys_rst)
    loopIdleRead |=> $stable(loopPtr_q))
    else $error("walk moved with nothing enabled");
  a_loop_no_skip: assert property (@(posedge clock) disable iff (sys_rst)
    loopStep |=> !slotBetween(slotEnable, $past(loopPtr_q), loopPtr_q))
    else $error("walk skipped an enabled slot");

  // loop data checked slot by slot against the status flags and the result inputs
  a_loop_status: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h0) |-> regRdata == {$past(ecgReady), $past(paceReady), $past(alarmSync), 1'b0})
    else $error("loop status byte wrong");
  a_loop_pace1_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h1) |-> regRdata == $past(pace1Result[15:8]))
    else $error("loop pace1 high byte wrong");
  a_loop_pace1_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h2) |-> regRdata == $past(pace1Result[7:0]))
    else $error("loop pace1 low byte wrong");
  a_loop_pace2_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h3) |-> regRdata == $past(pace2Result[15:8]))
    else $error("loop pace2 high byte wrong");
  a_loop_pace2_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h4) |-> regRdata == $past(pace2Result[7:0]))
    else $error("loop pace2 low byte wrong");
  a_loop_pace3_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h5) |-> regRdata == $past(pace3Result[15:8]))
    else $error("loop pace3 high byte wrong");
  a_loop_pace3_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h6) |-> regRdata == $past(pace3Result[7:0]))
    else $error("loop pace3 low byte wrong");
  a_loop_ecg1_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h7) |-> regRdata == $past(ecg1Result[23:16]))
    else $error("loop ecg1 high byte wrong");
  a_loop_ecg1_mid: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h8) |-> regRdata == $past(ecg1Result[15:8]))
    else $error("loop ecg1 middle byte wrong");
  a_loop_ecg1_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'h9) |-> regRdata == $past(ecg1Result[7:0]))
    else $error("loop ecg1 low byte wrong");
  a_loop_ecg2_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hA) |-> regRdata == $past(ecg2Result[23:16]))
    else $error("loop ecg2 high byte wrong");
  a_loop_ecg2_mid: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hB) |-> regRdata == $past(ecg2Result[15:8]))
    else $error("loop ecg2 middle byte wrong");
  a_loop_ecg2_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hC) |-> regRdata == $past(ecg2Result[7:0]))
    else $error("loop ecg2 low byte wrong");
  a_loop_ecg3_high: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hD) |-> regRdata == $past(ecg3Result[23:16]))
    else $error("loop ecg3 high byte wrong");
  a_loop_ecg3_mid: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hE) |-> regRdata == $past(ecg3Result[15:8]))
    else $error("loop ecg3 middle byte wrong");
  a_loop_ecg3_low: assert property (@(posedge clock) disable iff (sys_rst)
    loopLanded(4'hF) |-> regRdata == $past(ecg3Result[7:0]))
    else $error("loop ecg3 low byte wrong");
endmodule : result_readback

// ---- sim/result_host_model.sv ----
// host processor model that drives the register port of the result bank
`timescale 1ns/1ps
module result_host_model (
  input wire logic clock, // system clock
  output result_readback_pkg::byte_t regAddr, // register address
  output result_readback_pkg::byte_t regWdata, // write data
  output logic regWrite, // write strobe
  output logic regRead, // read strobe
  input wire result_readback_pkg::byte_t regRdata // read data
);
  import result_readback_pkg::*;
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // a released bus shows the inverted address so a stale decode cannot pass;
  // one idle edge follows the release so the next call never drives a signal twice in a step
  task automatic wr(input byte_t a, input byte_t d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    @(posedge clock);
  endtask : wr
  // data stand only in the cycle after the strobe, so they are taken at that edge
  task automatic rd(input byte_t a, output byte_t d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clock);
    d = regRdata;
  endtask : rd
endmodule : result_host_model

// ---- sim/result_readback_tb_top.sv ----
// self-checking bench for the result read-back bank
`timescale 1ns/1ps
`include "result_readback_defines.svh"
module result_readback_tb_top;
  import result_readback_pkg::*;
  localparam int LIMIT = 3000; // tests need about 330 cycles
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  byte_t regAddr, regWdata, regRdata, stat, got;
  logic regWrite, regRead, alarmActive;
  pace_t p1, p2, p3;
  ecg_t e1, e2, e3;
  logic [2:0] paceReady, ecgReady;
  logic [6:0] loopSelectConfig;
  logic [15:0] mask;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;
  logic [6:0] cfgs [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h55, 7'h7F};
  wire [119:0] allRes = {p1, p2, p3, e1, e2, e3};

  initial begin
    forever #2.5 clock = ~clock;
  end

  result_readback dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pace1Result(p1), .pace2Result(p2),
    .pace3Result(p3), .ecg1Result(e1), .ecg2Result(e2), .ecg3Result(e3), .paceReady(paceReady),
    .ecgReady(ecgReady), .alarmActive(alarmActive), .loopSelectConfig(loopSelectConfig));
  result_host_model host (.clock(clock), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata));

  function automatic byte_t expByte(input int a);
    if (a == 8'h30) return stat;
    if (a == 8'h40) return `REVISION_VALUE;
    if (a > 8'h40) return 8'h00;
    return allRes[119 - 8 * (a - 8'h31) -: 8];
  endfunction : expByte

  task automatic chk(input string name, input byte_t exp, input byte_t seen);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic completeRun();
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : completeRun

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errCount++;
      completeRun();
    end
  end

  initial begin
    p1 = 16'hA1B2;
    p2 = 16'hC3D4;
    p3 = 16'hE5F6;
    e1 = 24'h123456;
    e2 = 24'h789ABC;
    e3 = 24'hDEF012;
    paceReady = 3'h5;
    ecgReady = 3'h2;
    alarmActive = 1'b1;
    stat = {3'h2, 3'h5, 1'b1, 1'b0};
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    host.rd(`ADDR_LOOP_PORT, got);
    chk("loop idle", 8'h00, got);
    host.rd(`ADDR_LOOP_CONFIG, got);
    chk("config reset", 8'h00, got);
    // every byte is written first: a read-only place must keep its value
    for (int a = 8'h30; a <= 8'h41; a++) begin
      host.wr(byte_t'(a), 8'hFF);
      host.rd(byte_t'(a), got);
      chk("register byte", expByte(a), got);
    end
    host.rd(`ADDR_LOOP_CONFIG, got);
    chk("config after map writes", 8'h00, got);
    $display("test register map done");
    foreach (cfgs[i]) begin
      host.wr(`ADDR_LOOP_CONFIG, {1'b0, cfgs[i]});
      host.rd(`ADDR_LOOP_CONFIG, got);
      chk("config", {1'b0, cfgs[i]}, got);
      chk("config copy", {1'b0, cfgs[i]}, {1'b0, loopSelectConfig});
      mask = {{3{cfgs[i][6]}}, {3{cfgs[i][5]}}, {3{cfgs[i][4]}}, {2{cfgs[i][3]}}, {2{cfgs[i][2]}},
        {2{cfgs[i][1]}}, cfgs[i][0]};
      // two and a half passes so the wrap is seen
      for (int k = 0; k < 40; k++) begin
        if (mask[k % 16]) begin
          host.rd(`ADDR_LOOP_PORT, got);
          chk("loop byte", expByte(8'h30 + k % 16), got);
        end
      end
    end
    $display("test loop read-back done");
    // reset in mid-run with every enable set: all must fall back to disabled
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("config copy after reset", 8'h00, {1'b0, loopSelectConfig});
    host.rd(`ADDR_LOOP_CONFIG, got);
    chk("config after reset", 8'h00, got);
    host.rd(`ADDR_LOOP_PORT, got);
    chk("loop after reset", 8'h00, got);
    $display("test mid-run reset done");
    completeRun();
  end
endmodule : result_readback_tb_top
